//--- hw/oag_top.sv
`timescale 1ns/1ps
`default_nettype none
`include "oag_defs.svh"
module oag_top
  import oag_pkg::*;
(
  // clock and reset
  input wire logic clk_i,
  input wire logic rstn_i,
  // core state
  input wire oag_pkg::oag_core_t core_i,
  // operand address request and answer
  input wire oag_pkg::oag_req_t req_i,
  output oag_pkg::oag_opnd_t opnd_o,
  // external move request
  input wire logic xreq_valid_i,
  input wire oag_pkg::oag_xreq_t xreq_i,
  output logic xreq_ready_o,
  output logic xrd_valid_o,
  output logic [7:0] xrd_data_o,
  // off-chip bus pins
  output logic addr_strobe_o,
  output logic [7:0] p0_o,
  output logic p0_oe_o,
  input wire logic [7:0] p0_i,
  output logic [7:0] p2_o,
  output logic p2_addr_en_o,
  output logic rd_n_o,
  output logic wr_n_o,
  // port 0 latch overwrite pulse
  output logic p0_latch_set_o
);
  import oag_pkg::*;

  //////////////////////////////////////////////////////////////////////////////
  // reset release
  logic rst_q1;
  logic rst_n;
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      rst_q1 <= 1'b0;
      rst_n <= 1'b0;
    end else begin
      rst_q1 <= 1'b1;
      rst_n <= rst_q1;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // shared helpers
  function automatic logic [7:0] bank_base(input logic [7:0] program_status_word);
    bank_base = {3'b000, program_status_word[`OAG_PSW_RS1_BIT], program_status_word[`OAG_PSW_RS0_BIT], 3'b000};
  endfunction

  function automatic logic [15:0] idx_sum(input logic [15:0] base, input logic [7:0] acc);
    idx_sum = base + {8'h00, acc};
  endfunction

  //////////////////////////////////////////////////////////////////////////////
  // operand address generation, purely combinational
  logic [7:0] ind_ptr;
  always_comb begin
    opnd_o = '0;
    ind_ptr = req_i.reg_sel[0] ? core_i.r1 : core_i.r0;
    case (req_i.mode)
      OAG_MODE_IMM: begin
        opnd_o.imm = req_i.field;
        opnd_o.imm_valid = 1'b1;
      end
      OAG_MODE_DIR: begin
        opnd_o.addr = {8'h00, req_i.field};
        // upper half is special registers when named directly
        opnd_o.tgt = (req_i.field >= `OAG_UPPER_BASE) ? OAG_TGT_SFR : OAG_TGT_IRAM;
      end
      OAG_MODE_IND8: begin
        // never special registers: full 256 bytes of ram
        opnd_o.addr = {8'h00, req_i.use_sp ? core_i.sp : ind_ptr};
        opnd_o.tgt = OAG_TGT_IRAM;
      end
      OAG_MODE_REG: begin
        opnd_o.addr = {8'h00, bank_base(core_i.program_status_word) | {5'b00000, req_i.reg_sel}};
        opnd_o.tgt = OAG_TGT_IRAM;
      end
      OAG_MODE_SPEC: begin
        // implied register such as accumulator: nothing to address
        opnd_o.tgt = OAG_TGT_NONE;
      end
      OAG_MODE_IDX_DATA_POINTER_PAIR: begin
        opnd_o.addr = idx_sum(core_i.data_pointer_pair, core_i.acc);
        opnd_o.tgt = OAG_TGT_CODE;
      end
      OAG_MODE_IDX_PC: begin
        opnd_o.addr = idx_sum(core_i.pc, core_i.acc);
        opnd_o.tgt = OAG_TGT_CODE;
      end
      OAG_MODE_JMP_DATA_POINTER_PAIR: begin
        opnd_o.addr = idx_sum(core_i.data_pointer_pair, core_i.acc);
        opnd_o.tgt = OAG_TGT_CODE;
      end
      default: begin
        opnd_o = '0;
      end
    endcase
  end

  //////////////////////////////////////////////////////////////////////////////
  // external address selection
  logic aux_sel;
  logic [15:0] xaddr;
  logic x_onchip;
  assign aux_sel = core_i.io_cfg[`OAG_IO_CONFIG_REGISTER_AUX_BIT];
  always_comb begin
    if (xreq_i.kind == OAG_XM_DATA_POINTER_PAIR) begin
      xaddr = core_i.data_pointer_pair;
    end else begin
      xaddr[7:0] = xreq_i.ri_sel ? core_i.r1 : core_i.r0;
      // aux select keeps port 2 latch out of the address path
      xaddr[15:8] = aux_sel ? core_i.aux_hi : core_i.p2_latch;
    end
  end
  assign x_onchip = (xaddr <= `OAG_XRAM_LAST);

  //////////////////////////////////////////////////////////////////////////////
  // external move sequencer
  typedef enum logic [2:0] {
    OAG_ST_IDLE,
    OAG_ST_RAM,
    OAG_ST_ADDR,
    OAG_ST_DATA,
    OAG_ST_DONE
  } oag_xst_t;
  oag_xst_t state;
  logic [15:0] xaddr_q;
  logic wr_q;
  logic [7:0] wdata_q;
  logic ram_we;

  assign xreq_ready_o = (state == OAG_ST_IDLE);
  assign ram_we = xreq_valid_i && xreq_ready_o && x_onchip && xreq_i.wr;

  always_ff @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      state <= OAG_ST_IDLE;
      xaddr_q <= `OAG_RST_ADDR;
      wr_q <= 1'b0;
      wdata_q <= `OAG_RST_BYTE;
    end else begin
      case (state)
        OAG_ST_IDLE: begin
          if (xreq_valid_i) begin
            xaddr_q <= xaddr;
            wr_q <= xreq_i.wr;
            wdata_q <= xreq_i.wdata;
            // on-chip hits never touch the pins
            state <= x_onchip ? OAG_ST_RAM : OAG_ST_ADDR;
          end
        end
        OAG_ST_RAM: state <= OAG_ST_IDLE;
        OAG_ST_ADDR: state <= OAG_ST_DATA;
        OAG_ST_DATA: state <= OAG_ST_DONE;
        OAG_ST_DONE: state <= OAG_ST_IDLE;
        default: state <= OAG_ST_IDLE;
      endcase
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // on-chip external ram
  logic [7:0] ram_rdata;
  oag_xram #(
    .DEPTH(`OAG_XRAM_DEPTH),
    .AW(`OAG_XRAM_AW)
  ) u_xram (
    .clk_i(clk_i),
    .we_i(ram_we),
    .addr_i(xaddr[`OAG_XRAM_AW-1:0]),
    .wdata_i(xreq_i.wdata),
    .rdata_o(ram_rdata)
  );

  //////////////////////////////////////////////////////////////////////////////
  // off-chip pins, registered
  always_ff @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      addr_strobe_o <= 1'b0;
      p0_o <= `OAG_RST_PORT;
      p0_oe_o <= 1'b0;
      p2_o <= `OAG_RST_PORT;
      p2_addr_en_o <= 1'b0;
      rd_n_o <= 1'b1;
      wr_n_o <= 1'b1;
      p0_latch_set_o <= 1'b0;
    end else begin
      addr_strobe_o <= 1'b0;
      rd_n_o <= 1'b1;
      wr_n_o <= 1'b1;
      p0_latch_set_o <= 1'b0;
      if (state == OAG_ST_IDLE && xreq_valid_i && !x_onchip) begin
        // address phase: low byte on port 0, strobe high
        addr_strobe_o <= 1'b1;
        p0_o <= xaddr[7:0];
        p0_oe_o <= 1'b1;
        p2_o <= xaddr[15:8];
        p2_addr_en_o <= 1'b1;
        // port 0 latch is overwritten with all ones by any off-chip access
        p0_latch_set_o <= 1'b1;
      end else if (state == OAG_ST_ADDR) begin
        // data phase: drive write data or release for read
        p0_o <= wr_q ? wdata_q : `OAG_RST_PORT;
        p0_oe_o <= wr_q;
        wr_n_o <= !wr_q;
        rd_n_o <= wr_q;
      end else if (state == OAG_ST_DATA) begin
        p0_oe_o <= 1'b0;
        p2_addr_en_o <= 1'b0;
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // read return
  always_ff @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      xrd_valid_o <= 1'b0;
      xrd_data_o <= `OAG_RST_BYTE;
    end else begin
      xrd_valid_o <= 1'b0;
      if (state == OAG_ST_RAM && !wr_q) begin
        xrd_valid_o <= 1'b1;
        xrd_data_o <= ram_rdata;
      end else if (state == OAG_ST_DATA && !wr_q) begin
        // pins sampled while read strobe is low, same-clock bus
        xrd_valid_o <= 1'b1;
        xrd_data_o <= p0_i;
      end
    end
  end
endmodule // oag_top
`default_nettype wire

//--- hw/oag_defs.svh
`ifndef OAG_DEFS_SVH
`define OAG_DEFS_SVH
// on-chip external ram window 0000h..3fffh
`define OAG_XRAM_DEPTH 16384
`define OAG_XRAM_AW 14
`define OAG_XRAM_LAST 16'h3fff
// direct/indirect split of the internal space
`define OAG_UPPER_BASE 8'h80
// io config bit that selects the aux high address source
`define OAG_IO_CONFIG_REGISTER_AUX_BIT 3
// psw bank select bit positions
`define OAG_PSW_RS0_BIT 3
`define OAG_PSW_RS1_BIT 4
// reset values
`define OAG_RST_BYTE 8'h00
`define OAG_RST_PORT 8'hff
`define OAG_RST_ADDR 16'h0000
`endif

//--- hw/oag_pkg.sv
package oag_pkg;
  // operand address modes
  typedef enum logic [2:0] {
    OAG_MODE_IMM,
    OAG_MODE_DIR,
    OAG_MODE_IND8,
    OAG_MODE_REG,
    OAG_MODE_SPEC,
    OAG_MODE_IDX_DATA_POINTER_PAIR,
    OAG_MODE_IDX_PC,
    OAG_MODE_JMP_DATA_POINTER_PAIR
  } oag_mode_t;
  // operand targets: none, internal ram, special registers or code space
  typedef enum logic [1:0] {
    OAG_TGT_NONE,
    OAG_TGT_IRAM,
    OAG_TGT_SFR,
    OAG_TGT_CODE
  } oag_tgt_t;
  // external move kinds
  typedef enum logic {
    OAG_XM_RI,
    OAG_XM_DATA_POINTER_PAIR
  } oag_xkind_t;
  // core state consumed by the generator
  typedef struct packed {
    logic [7:0] acc;
    logic [7:0] program_status_word;
    logic [7:0] sp;
    logic [15:0] data_pointer_pair;
    logic [15:0] pc;
    logic [7:0] p2_latch;
    logic [7:0] aux_hi;
    logic [7:0] io_cfg;
    logic [7:0] r0;
    logic [7:0] r1;
  } oag_core_t;
  // operand request
  typedef struct packed {
    oag_mode_t mode;
    logic [7:0] field;
    logic [2:0] reg_sel;
    logic use_sp;
  } oag_req_t;
  // operand address answer
  typedef struct packed {
    oag_tgt_t tgt;
    logic [15:0] addr;
    logic [7:0] imm;
    logic imm_valid;
  } oag_opnd_t;
  // external move request
  typedef struct packed {
    oag_xkind_t kind;
    logic ri_sel;
    logic wr;
    logic [7:0] wdata;
  } oag_xreq_t;
endpackage

//--- hw/oag_xram.sv
`timescale 1ns/1ps
`default_nettype none
`include "oag_defs.svh"
module oag_xram #(
  parameter int DEPTH = `OAG_XRAM_DEPTH,
  parameter int AW = `OAG_XRAM_AW
) (
  // clock
  input wire logic clk_i,
  // access
  input wire logic we_i,
  input wire logic [AW-1:0] addr_i,
  input wire logic [7:0] wdata_i,
  output logic [7:0] rdata_o
);
  logic [7:0] mem [DEPTH];
  // no reset on the array, read data registered
  always_ff @(posedge clk_i) begin
    if (we_i) begin
      mem[addr_i] <= wdata_i;
    end
    rdata_o <= mem[addr_i];
  end
endmodule // oag_xram
`default_nettype wire

//--- testbench/oag_monitor.sv
`timescale 1ns/1ps
`default_nettype none
module oag_mon
  import oag_pkg::*;
(
  // clock and reset
  input wire logic clk_i,
  input wire logic rstn_i,
  // operand side
  input wire oag_pkg::oag_core_t core_i,
  input wire oag_pkg::oag_req_t req_i,
  input wire oag_pkg::oag_opnd_t opnd_o,
  // external move side
  input wire logic xreq_valid_i,
  input wire oag_pkg::oag_xreq_t xreq_i,
  input wire logic xreq_ready_o,
  input wire logic xrd_valid_o,
  input wire logic addr_strobe_o,
  input wire logic p0_oe_o,
  input wire logic p2_addr_en_o,
  input wire logic p0_latch_set_o,
  input wire logic rd_n_o,
  input wire logic wr_n_o
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rstn_i);
  logic take;
  logic [15:0] xa;
  assign take = xreq_valid_i && xreq_ready_o;
  // address the move should use, worked out from the core state at the take
  assign xa = (xreq_i.kind == OAG_XM_DATA_POINTER_PAIR) ? core_i.data_pointer_pair :
    {core_i.io_cfg[3] ? core_i.aux_hi : core_i.p2_latch, xreq_i.ri_sel ? core_i.r1 : core_i.r0};
  chk_imm_const: assert property (req_i.mode == OAG_MODE_IMM |->
    opnd_o.imm_valid && opnd_o.imm == req_i.field) else $error("immediate wrong");
  chk_dir_space: assert property (req_i.mode == OAG_MODE_DIR |-> opnd_o.addr[7:0] == req_i.field &&
    opnd_o.tgt == (req_i.field[7] ? OAG_TGT_SFR : OAG_TGT_IRAM)) else $error("direct wrong");
  chk_ind_ptr: assert property (req_i.mode == OAG_MODE_IND8 |-> opnd_o.tgt == OAG_TGT_IRAM &&
    opnd_o.addr[7:0] == (req_i.use_sp ? core_i.sp : req_i.reg_sel[0] ? core_i.r1 : core_i.r0))
    else $error("indirect wrong");
  chk_idx_data_pointer_pair: assert property (req_i.mode inside {OAG_MODE_IDX_DATA_POINTER_PAIR, OAG_MODE_JMP_DATA_POINTER_PAIR} |->
    opnd_o.addr == core_i.data_pointer_pair + core_i.acc) else $error("data_pointer_pair sum wrong");
  chk_idx_pc: assert property (req_i.mode == OAG_MODE_IDX_PC |->
    opnd_o.tgt == OAG_TGT_CODE && opnd_o.addr == core_i.pc + core_i.acc) else $error("pc sum wrong");
  chk_onchip_quiet: assert property (take && xa <= 16'h3fff |->
    (!addr_strobe_o && !p2_addr_en_o)[*4]) else $error("on-chip move left chip");
  chk_offchip_strobe: assert property (take && xa > 16'h3fff |-> ##[1:2] addr_strobe_o)
    else $error("no address strobe");
  chk_strobe_pins: assert property (addr_strobe_o |-> p0_oe_o && p2_addr_en_o && p0_latch_set_o
    ##1 !addr_strobe_o) else $error("address phase wrong");
  chk_read_turn: assert property ($fell(rd_n_o) |-> $past(addr_strobe_o) ##1 rd_n_o && xrd_valid_o)
    else $error("read phase wrong");
  chk_write_turn: assert property (!wr_n_o |-> $past(addr_strobe_o) && p0_oe_o ##1 wr_n_o)
    else $error("write phase wrong");
endmodule // oag_mon
bind oag_top oag_mon u_oag_mon (.clk_i, .rstn_i, .core_i, .req_i, .opnd_o, .xreq_valid_i, .xreq_i,
  .xreq_ready_o, .xrd_valid_o, .addr_strobe_o, .p0_oe_o, .p2_addr_en_o, .p0_latch_set_o, .rd_n_o, .wr_n_o);
`default_nettype wire

//--- testbench/oag_xmem.sv
`timescale 1ns/1ps
`default_nettype none
module oag_xmem (
  // bus from the block
  input wire logic clk_i,
  input wire logic strobe_i,
  input wire logic [7:0] ad_i,
  input wire logic ad_oe_i,
  input wire logic [7:0] hi_i,
  input wire logic rd_n_i,
  input wire logic wr_n_i,
  // bus back and bookkeeping
  output logic [7:0] ad_o,
  output logic [15:0] la_o,
  output logic [7:0] ns_o
);
  logic [7:0] mem [0:65535];
  logic [7:0] idle = 8'h5a;
  logic [7:0] ns = 8'h00;
  assign ns_o = ns;
  // a released bus must not keep the last byte
  assign ad_o = !rd_n_i ? mem[la_o] : ad_oe_i ? ad_i : idle;
  always @(posedge clk_i) begin
    idle <= ~idle;
    if (strobe_i) begin
      la_o <= {hi_i, ad_i};
      ns <= ns + 8'h01;
    end
    if (!wr_n_i) mem[la_o] <= ad_i;
  end
endmodule // oag_xmem
`default_nettype wire

//--- testbench/operand_address_generation_test.sv
`timescale 1ns/1ps
`default_nettype none
module operand_address_generation_test;
  import oag_pkg::*;
  logic clk_i = 1'b0;
  logic rstn_i = 1'b0;
  oag_core_t core_i = '0;
  oag_core_t c;
  oag_req_t req_i = '0;
  oag_xreq_t xreq_i = '0;
  logic xreq_valid_i = 1'b0;
  oag_opnd_t opnd_o;
  logic xreq_ready_o, xrd_valid_o, addr_strobe_o, p0_oe_o, p2_addr_en_o, rd_n_o, wr_n_o, p0_latch_set_o;
  logic [7:0] xrd_data_o, p0_o, p0_i, p2_o, ns;
  logic [15:0] la;
  int mismatches = 0;
  int n_compared = 0;
  int cyc = 0;
  always #20 clk_i = ~clk_i;
  oag_top u_oag_top (.clk_i, .rstn_i, .core_i, .req_i, .opnd_o, .xreq_valid_i, .xreq_i, .xreq_ready_o,
    .xrd_valid_o, .xrd_data_o, .addr_strobe_o, .p0_o, .p0_oe_o, .p0_i, .p2_o, .p2_addr_en_o, .rd_n_o,
    .wr_n_o, .p0_latch_set_o);
  oag_xmem u_oag_xmem (.clk_i, .strobe_i(addr_strobe_o), .ad_i(p0_o), .ad_oe_i(p0_oe_o), .hi_i(p2_o),
    .rd_n_i(rd_n_o), .wr_n_i(wr_n_o), .ad_o(p0_i), .la_o(la), .ns_o(ns));
  ////////////////////////////////////////
  task automatic cmp(input logic [17:0] got, input logic [17:0] exp);
    n_compared++;
    if (got !== exp) begin
      mismatches++;
      $display("ERROR %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic complete_run;
    $display("compared %0d mismatches %0d", n_compared, mismatches);
    if (mismatches == 0 && n_compared > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  task automatic setc;
    @(posedge clk_i);
    core_i <= c;
  endtask
  task automatic opnd(input oag_mode_t m, input logic [7:0] f, input logic s, input logic [17:0] e);
    @(posedge clk_i);
    req_i <= '{mode: m, field: f, reg_sel: f[2:0], use_sp: s};
    @(negedge clk_i);
    if (m == OAG_MODE_IMM) cmp({9'h0, opnd_o.imm_valid, opnd_o.imm}, e);
    else if (m == OAG_MODE_JMP_DATA_POINTER_PAIR) cmp({2'h0, opnd_o.addr}, e);
    else if (m == OAG_MODE_SPEC) cmp({opnd_o.tgt, 16'h0}, e);
    else cmp({opnd_o.tgt, opnd_o.addr}, e);
  endtask
  // request held until the take edge; read data waited for under a bound
  task automatic xfer(input oag_xkind_t k, input logic r, input logic w, input logic [7:0] d,
    output logic [7:0] q);
    int n;
    n = 0;
    @(posedge clk_i);
    xreq_i <= '{kind: k, ri_sel: r, wr: w, wdata: d};
    xreq_valid_i <= 1'b1;
    do @(negedge clk_i); while (!xreq_ready_o && ++n < 20);
    if (xreq_ready_o !== 1'b1) begin
      mismatches++;
      $display("ERROR %0t request never taken", $time);
    end
    @(posedge clk_i);
    xreq_valid_i <= 1'b0;
    while (!w && xrd_valid_o !== 1'b1 && n < 40) begin
      @(negedge clk_i);
      n++;
    end
    if (!w && xrd_valid_o !== 1'b1) begin
      mismatches++;
      $display("ERROR %0t read data never returned", $time);
    end
    q = xrd_data_o;
  endtask
  ////////////////////////////////////////
  task automatic t_modes;
    c = '{acc: 8'h20, program_status_word: 8'h18, sp: 8'hc7, data_pointer_pair: 16'h12f0, pc: 16'hfff0, p2_latch: 8'h85,
      aux_hi: 8'h12, io_cfg: 8'h00, r0: 8'h11, r1: 8'h34};
    setc();
    opnd(OAG_MODE_IMM, 8'h5c, 1'b0, 18'h0015c);
    opnd(OAG_MODE_DIR, 8'h7f, 1'b0, 18'h1007f);
    opnd(OAG_MODE_DIR, 8'h80, 1'b0, 18'h20080);
    opnd(OAG_MODE_IND8, 8'h01, 1'b0, 18'h10034);
    opnd(OAG_MODE_IND8, 8'h00, 1'b1, 18'h100c7);
    opnd(OAG_MODE_REG, 8'h05, 1'b0, 18'h1001d);
    opnd(OAG_MODE_SPEC, 8'h00, 1'b0, 18'h00000);
    opnd(OAG_MODE_IDX_DATA_POINTER_PAIR, 8'h00, 1'b0, 18'h31310);
    opnd(OAG_MODE_IDX_PC, 8'h00, 1'b0, 18'h30010);
    opnd(OAG_MODE_JMP_DATA_POINTER_PAIR, 8'h00, 1'b0, 18'h01310);
    $display("t_modes done");
  endtask
  task automatic t_onchip;
    logic [7:0] q;
    c.io_cfg = 8'h08;
    c.p2_latch = 8'hc0;
    setc();
    xfer(OAG_XM_RI, 1'b1, 1'b1, 8'ha5, q);
    c.data_pointer_pair = 16'h1234;
    setc();
    xfer(OAG_XM_DATA_POINTER_PAIR, 1'b0, 1'b0, 8'h00, q);
    cmp({10'h0, q}, 18'h000a5);
    c.data_pointer_pair = 16'h3fff;
    setc();
    xfer(OAG_XM_DATA_POINTER_PAIR, 1'b0, 1'b1, 8'h3c, q);
    xfer(OAG_XM_DATA_POINTER_PAIR, 1'b0, 1'b0, 8'h00, q);
    cmp({10'h0, q}, 18'h0003c);
    cmp({10'h0, ns}, 18'h00000);
    $display("t_onchip done");
  endtask
  task automatic t_offchip;
    logic [7:0] q;
    c.io_cfg = 8'h00;
    c.data_pointer_pair = 16'h4000;
    setc();
    xfer(OAG_XM_DATA_POINTER_PAIR, 1'b0, 1'b1, 8'h77, q);
    xfer(OAG_XM_DATA_POINTER_PAIR, 1'b0, 1'b0, 8'h00, q);
    cmp({10'h0, q}, 18'h00077);
    cmp({2'h0, la}, 18'h04000);
    c.p2_latch = 8'h85;
    c.data_pointer_pair = 16'h8511;
    setc();
    xfer(OAG_XM_RI, 1'b0, 1'b1, 8'h9e, q);
    xfer(OAG_XM_DATA_POINTER_PAIR, 1'b0, 1'b0, 8'h00, q);
    cmp({10'h0, q}, 18'h0009e);
    cmp({10'h0, ns}, 18'h00004);
    $display("t_offchip done");
  endtask
  ////////////////////////////////////////
  // bound is far above the fewer than a hundred cycles the tests need
  always @(posedge clk_i) begin
    cyc++;
    if (cyc == 2000) begin
      mismatches++;
      complete_run();
    end
  end
  initial begin
    repeat (12) @(posedge clk_i);
    cmp({14'h0, rd_n_o, wr_n_o, p0_oe_o, addr_strobe_o}, 18'h0000c);
    rstn_i <= 1'b1;
    repeat (5) @(posedge clk_i);
    t_modes();
    t_onchip();
    t_offchip();
    complete_run();
  end
endmodule // operand_address_generation_test
`default_nettype wire
